// >>> src/dxbus_map.svh
// Constants for the external bus and reset block.
`ifndef DXBUS_MAP_SVH
`define DXBUS_MAP_SVH
`define DXBUS_ADDR_W 16
`define DXBUS_DATA_W 16
`define DXBUS_PORT_W 3
`define DXBUS_ADDR_RST 16'h0000
`define DXBUS_CLK_PERIOD_NS 10
`define DXBUS_RST_MIN_CYC 5
`define DXBUS_CMD_W 3
`endif

// >>> src/dxbus_pkg.sv
// Types for the external bus and reset block.
package dxbus_pkg;
    typedef enum logic [2:0] {
        DXBUS_CMD_FETCH = 3'h0,
        DXBUS_CMD_DREAD = 3'h1,
        DXBUS_CMD_PIN = 3'h2,
        DXBUS_CMD_POUT = 3'h3,
        DXBUS_CMD_TABLE_WRITE_INSTR = 3'h4,
        DXBUS_CMD_IDLE = 3'h5
    } dxbus_cmd_t;
    typedef enum logic [1:0] {
        DXBUS_ST_RESET,
        DXBUS_ST_CLEAR,
        DXBUS_ST_WAKE,
        DXBUS_ST_RUN
    } dxbus_state_t;
endpackage

// >>> src/dxbus_core.sv
// External memory and port bus master with synchronised reset.
`timescale 1ns/1ns
`include "dxbus_map.svh"

// Contract
// - Reset holds strobes high, data bus floated
// - Address and PC cleared after one cycle
// - Ready for fetches two cycles after synchronised release
// - Reset input synchronised to the clock
// - At most one strobe low per cycle
// - Interrupted write address may be invalid
// - Address outputs always driven
// - Port number on low three address lines
// - Upper thirteen address lines low on ports
// - Data driven only during write strobes
// - Write strobes only for their instructions
// - Port read strobe only on port input
module dxbus_core (
    input wire logic core_clk, // Processor clock
    input wire logic rstn, // Power-on reset, active low
    input wire logic reset_in_n, // External reset pin, active low
    input wire dxbus_pkg::dxbus_cmd_t cmd, // Bus cycle requested this cycle
    input wire logic [15:0] cmd_addr, // Memory address for memory cycles
    input wire logic [2:0] cmd_port, // Port number for port cycles
    input wire logic [15:0] cmd_wdata, // Write data for port or table write
    output logic cmd_ready, // Core may issue bus cycles
    output logic [15:0] pc, // Program counter
    output logic [15:0] address_outputs, // Address bus, always driven
    output logic data_read_strobe_n, // Data read strobe
    output logic program_fetch_strobe_n, // Program fetch strobe
    output logic port_write_strobe_n, // Port write strobe
    output logic memory_write_strobe_n, // Memory write strobe
    output logic port_read_strobe_n, // Port read strobe
    output logic [15:0] data_out, // Data bus output
    output logic data_oe, // Data bus output enable
    input wire logic [15:0] data_in, // Data bus input
    output logic [15:0] rdata // Data captured by the last read
);
    import dxbus_pkg::*;

    logic rs_meta_r;
    logic rs_sync_r;
    dxbus_state_t state_r;
    logic run;
    logic rd_cycle;

    // Port cycles put the port number on the address bus instead of a memory address
    function automatic logic is_port_cmd(input dxbus_cmd_t c);
        return (c == DXBUS_CMD_PIN) || (c == DXBUS_CMD_POUT);
    endfunction

    // Only these two cycles turn the data bus around and drive it
    function automatic logic is_write_cmd(input dxbus_cmd_t c);
        return (c == DXBUS_CMD_POUT) || (c == DXBUS_CMD_TABLE_WRITE_INSTR);
    endfunction

    // Two-stage synchroniser; entry and exit latency vary with edge position
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rs_meta_r <= 1'b0;
            rs_sync_r <= 1'b0;
        end else begin
            rs_meta_r <= reset_in_n;
            rs_sync_r <= rs_meta_r;
        end
    end

    // a pulse shorter than the synchroniser may be missed entirely
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= DXBUS_ST_RESET;
        end else if (!rs_sync_r) begin
            state_r <= DXBUS_ST_CLEAR;
        end else begin
            unique case (state_r)
                DXBUS_ST_RESET: state_r <= DXBUS_ST_WAKE;
                DXBUS_ST_CLEAR: state_r <= DXBUS_ST_WAKE;
                DXBUS_ST_WAKE: state_r <= DXBUS_ST_RUN;
                DXBUS_ST_RUN: state_r <= DXBUS_ST_RUN;
            endcase
        end
    end

    assign run = (state_r == DXBUS_ST_RUN) && rs_sync_r;
    // Any read strobe low: the far side owns the data bus this cycle
    assign rd_cycle = !data_read_strobe_n || !port_read_strobe_n || !program_fetch_strobe_n;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_ready <= 1'b0;
        end else begin
            cmd_ready <= rs_sync_r && (state_r == DXBUS_ST_WAKE || state_r == DXBUS_ST_RUN);
        end
    end

    // Strobes: one-hot low, all high in reset; registered so no glitches
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            data_read_strobe_n <= 1'b1;
            program_fetch_strobe_n <= 1'b1;
            port_write_strobe_n <= 1'b1;
            memory_write_strobe_n <= 1'b1;
            port_read_strobe_n <= 1'b1;
        end else begin
            data_read_strobe_n <= !(run && cmd == DXBUS_CMD_DREAD);
            program_fetch_strobe_n <= !(run && cmd == DXBUS_CMD_FETCH);
            port_write_strobe_n <= !(run && cmd == DXBUS_CMD_POUT);
            memory_write_strobe_n <= !(run && cmd == DXBUS_CMD_TABLE_WRITE_INSTR);
            port_read_strobe_n <= !(run && cmd == DXBUS_CMD_PIN);
        end
    end

    // Address is a plain register: never floated
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            address_outputs <= `DXBUS_ADDR_RST;
            pc <= `DXBUS_ADDR_RST;
        end else if (state_r == DXBUS_ST_CLEAR || !rs_sync_r) begin
            // Cleared one cycle after reset is seen; a write cut off here loses its address
            address_outputs <= `DXBUS_ADDR_RST;
            pc <= `DXBUS_ADDR_RST;
        end else if (run) begin
            if (is_port_cmd(cmd)) begin
                address_outputs <= {13'h0000, cmd_port};
            end else if (cmd != DXBUS_CMD_IDLE) begin
                address_outputs <= cmd_addr;
            end
            if (cmd == DXBUS_CMD_FETCH) begin
                pc <= cmd_addr + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            data_oe <= 1'b0;
            data_out <= 16'h0000;
        end else begin
            data_oe <= run && is_write_cmd(cmd);
            data_out <= (run && is_write_cmd(cmd)) ? cmd_wdata : 16'h0000;
        end
    end

    // Read data taken at the end of each read strobe cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else begin
            if (rd_cycle) begin
                rdata <= data_in;
            end
        end
    end

    // Strobes are one-hot low or all high
    a_strobe_onehot: assert property (@(posedge core_clk) disable iff (!rstn)
        $onehot0({~data_read_strobe_n, ~program_fetch_strobe_n, ~port_write_strobe_n,
                  ~memory_write_strobe_n, ~port_read_strobe_n}))
        else $error("more than one strobe low");

    a_data_drive_only: assert property (@(posedge core_clk) disable iff (!rstn)
        data_oe == (!port_write_strobe_n || !memory_write_strobe_n))
        else $error("data bus driven outside write strobe");

    a_write_data_value: assert property (@(posedge core_clk) disable iff (!rstn)
        data_oe |-> (data_out == $past(cmd_wdata)))
        else $error("wrong word on data bus");

    a_port_addr_high: assert property (@(posedge core_clk) disable iff (!rstn)
        (!port_read_strobe_n || !port_write_strobe_n) |-> address_outputs[15:3] == 13'h0000)
        else $error("upper address not low on port cycle");

    a_port_addr_num: assert property (@(posedge core_clk) disable iff (!rstn)
        (run && is_port_cmd(cmd)) |=> address_outputs[2:0] == $past(cmd_port))
        else $error("port number not on address");

    a_idle_addr_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        (run && cmd == DXBUS_CMD_IDLE) |=> $stable(address_outputs))
        else $error("address moved on an idle cycle");

    // Reset entry and exit take several cycles, so they are spelt out as sequences
    sequence s_reset_seen;
        !rs_sync_r;
    endsequence

    sequence s_wake_wait;
        !cmd_ready ##1 !cmd_ready;
    endsequence

    a_reset_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        s_reset_seen |=> (data_read_strobe_n && program_fetch_strobe_n && port_write_strobe_n
                          && memory_write_strobe_n && port_read_strobe_n && !data_oe))
        else $error("strobe or data active in reset");

    a_reset_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        s_reset_seen ##1 !rs_sync_r |=> (address_outputs == 16'h0000 && pc == 16'h0000))
        else $error("address not cleared in reset");

    a_resume_ready: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(rs_sync_r) |-> s_wake_wait ##1 cmd_ready)
        else $error("resume timing wrong");

    a_sync_delay: assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(reset_in_n) |=> ##1 !rs_sync_r)
        else $error("reset not seen after two edges");

    a_fetch_after_ready: assert property (@(posedge core_clk) disable iff (!rstn)
        !program_fetch_strobe_n |-> $past(cmd_ready))
        else $error("fetch before resume");

    a_pc_step: assert property (@(posedge core_clk) disable iff (!rstn)
        !program_fetch_strobe_n |-> (pc == $past(cmd_addr) + 16'h0001))
        else $error("program counter not advanced by fetch");

    a_write_strobe_src: assert property (@(posedge core_clk) disable iff (!rstn)
        !memory_write_strobe_n |-> $past(cmd) == DXBUS_CMD_TABLE_WRITE_INSTR)
        else $error("memory write without table write");

    a_port_write_src: assert property (@(posedge core_clk) disable iff (!rstn)
        !port_write_strobe_n |-> ($past(cmd) == DXBUS_CMD_POUT && $past(run)))
        else $error("port write without port output");

    a_port_read_src: assert property (@(posedge core_clk) disable iff (!rstn)
        !port_read_strobe_n |-> ($past(cmd) == DXBUS_CMD_PIN && $past(run)))
        else $error("port read without port input");

    a_read_capture: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_cycle |=> (rdata == $past(data_in)))
        else $error("read data not captured");
endmodule // dxbus_core

// >>> bench/dxbus_mem_model.sv
// Program memory and port peripherals on the far side of the bus.
`timescale 1ns/1ns
module dxbus_mem_model (
    input wire logic core_clk, // Processor clock
    input wire logic [15:0] address_outputs, // Address bus
    input wire logic rd_n, // Any read strobe low
    output logic [15:0] mem_data // Value offered to the data bus
);
    logic [15:0] last_r = 16'h0000;
    // Writes are not stored, so an interrupted write address is never trusted
    // A released bus toggles every cycle rather than holding a stale word
    always_comb mem_data = !rd_n ? (address_outputs ^ 16'ha5c3) : ~last_r;
    always_ff @(posedge core_clk) last_r <= mem_data;
endmodule // dxbus_mem_model

// >>> bench/dxbus_core_tb.sv
// Self-checking bench for the external bus and reset block.
`timescale 1ns/1ns
module dxbus_core_tb;
    import dxbus_pkg::*;
    // Row: command, address, port, write data; expected strobes (read, fetch, pwrite, mwrite, pread) and bus
    typedef struct packed {dxbus_cmd_t c; logic [15:0] a; logic [2:0] p; logic [15:0] w; logic [4:0] s;
        logic [15:0] ea;} dxbus_row_t;
    logic core_clk = 1'b0, rstn = 1'b0, reset_in_n = 1'b1, cmd_ready, data_oe;
    dxbus_cmd_t cmd = DXBUS_CMD_IDLE;
    logic [15:0] cmd_addr = 16'h0000, cmd_wdata = 16'h0000, pc, address_outputs, data_out, data_in, rdata, mem_data;
    logic [2:0] cmd_port = 3'h0;
    logic [4:0] strb;
    int err_count = 0, compares = 0;
    dxbus_row_t rows [5] = '{'{DXBUS_CMD_FETCH, 16'h1234, 3'h0, 16'h0000, 5'h17, 16'h1234},
        '{DXBUS_CMD_DREAD, 16'hfffe, 3'h0, 16'h0000, 5'h0f, 16'hfffe},
        '{DXBUS_CMD_PIN, 16'hffff, 3'h7, 16'h0000, 5'h1e, 16'h0007},
        '{DXBUS_CMD_POUT, 16'hffff, 3'h5, 16'hc3a5, 5'h1b, 16'h0005},
        '{DXBUS_CMD_TABLE_WRITE_INSTR, 16'h8001, 3'h2, 16'h5a0f, 5'h1d, 16'h8001}};
    assign data_in = data_oe ? data_out : mem_data;
    dxbus_core dxbus_core_i (.core_clk(core_clk), .rstn(rstn), .reset_in_n(reset_in_n), .cmd(cmd),
        .cmd_addr(cmd_addr), .cmd_port(cmd_port), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .pc(pc),
        .address_outputs(address_outputs), .data_read_strobe_n(strb[4]), .program_fetch_strobe_n(strb[3]),
        .port_write_strobe_n(strb[2]), .memory_write_strobe_n(strb[1]), .port_read_strobe_n(strb[0]),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .rdata(rdata));
    dxbus_mem_model dxbus_mem_model_i (.core_clk(core_clk), .address_outputs(address_outputs),
        .rd_n(strb[4] & strb[3] & strb[0]), .mem_data(mem_data));
    initial forever #5 core_clk = ~core_clk;
    task automatic report_and_stop;
        $display("Comparisons %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_strb(input logic [4:0] e);
        compares++;
        if (strb !== e) begin
            err_count++;
            $display("ERROR strobes expected %b seen %b", e, strb);
        end
    endtask
    // Inputs change at rising edges; outputs are looked at on falling edges, where they have settled
    task automatic wait_ready;
        int n;
        n = 0;
        @(negedge core_clk);
        while (cmd_ready !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        chk_val("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
        if (cmd_ready !== 1'b1) report_and_stop;
    endtask
    task automatic run_row(input dxbus_row_t r);
        logic wr;
        wr = !(r.s[2] & r.s[1]);
        @(posedge core_clk);
        cmd <= r.c;
        cmd_addr <= r.a;
        cmd_port <= r.p;
        cmd_wdata <= r.w;
        @(posedge core_clk);
        cmd <= DXBUS_CMD_IDLE;
        @(negedge core_clk);
        chk_strb(r.s);
        chk_val("address", r.ea, address_outputs);
        chk_val("data_oe", {15'h0000, wr}, {15'h0000, data_oe});
        if (wr) chk_val("data_out", r.w, data_out);
        @(negedge core_clk);
        chk_strb(5'h1f);
        chk_val("address held", r.ea, address_outputs);
        if (!wr) chk_val("rdata", r.ea ^ 16'ha5c3, rdata);
        if (r.c == DXBUS_CMD_FETCH) chk_val("pc", r.a + 16'h0001, pc);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk_strb(5'h1f);
        chk_val("data_oe", 16'h0000, {15'h0000, data_oe});
        chk_val("address", 16'h0000, address_outputs);
        @(posedge core_clk);
        rstn <= 1'b1;
        cmd <= DXBUS_CMD_TABLE_WRITE_INSTR;
        // A write asked for while waking up must be ignored
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk_strb(5'h1f);
        @(posedge core_clk);
        cmd <= DXBUS_CMD_IDLE;
        wait_ready;
        foreach (rows[i]) run_row(rows[i]);
        @(posedge core_clk);
        cmd <= DXBUS_CMD_TABLE_WRITE_INSTR;
        cmd_addr <= 16'h4321;
        repeat (3) @(negedge core_clk);
        chk_strb(5'h1d);
        chk_val("back to back", 16'h0001, {15'h0000, data_oe});
        chk_val("address", 16'h4321, address_outputs);
        // Reset lands in the middle of a run of table writes
        @(posedge core_clk);
        reset_in_n <= 1'b0;
        repeat (4) @(negedge core_clk);
        chk_strb(5'h1f);
        chk_val("data_oe", 16'h0000, {15'h0000, data_oe});
        @(negedge core_clk);
        chk_val("address", 16'h0000, address_outputs);
        chk_val("pc", 16'h0000, pc);
        @(posedge core_clk);
        reset_in_n <= 1'b1;
        cmd <= DXBUS_CMD_IDLE;
        wait_ready;
        run_row(rows[0]);
        report_and_stop;
    end
endmodule // dxbus_core_tb
